// ---- rtl/hsc_clk_policy.v ----
`timescale 1ns/1ps
`include "hsc_consts.vh"

// ==========================================================================
// Clock source policy: enables for run and for halt
// ==========================================================================
module hsc_clk_policy (
   // State
   input  wire                   i_halted,
   input  wire [`HSC_SRC_W-1:0]  i_src,
   // Requests while running
   input  wire                   i_fast_req,
   input  wire                   i_xtal_req,
   input  wire                   i_ext_req,
   input  wire                   i_sub_req,
   input  wire                   i_slow_req,
   // Snapshot taken at halt entry
   input  wire                   i_fast_prev,
   input  wire                   i_xtal_prev,
   input  wire                   i_ext_prev,
   input  wire                   i_sub_prev,
   // Option byte
   input  wire                   i_wdt_on,
   input  wire                   i_wdt_stby,
   // Enables
   output reg                    o_fast_en,
   output reg                    o_xtal_en,
   output reg                    o_ext_en,
   output reg                    o_sub_en,
   output reg                    o_slow_en,
   output reg                    o_wdt_run
);

   // Picks the forced value when the source matches, else the snapshot
   function hsc_keep;
      input force_on;
      input prev;
      begin
         hsc_keep = force_on | prev;
      end
   endfunction

   // Halt table; run mode follows the clock generator requests, with the slow oscillator also on when the watchdog option is set
   always @* begin
      o_fast_en = i_fast_req;
      o_xtal_en = i_xtal_req;
      o_ext_en  = i_ext_req;
      o_sub_en  = i_sub_req;
      o_slow_en = i_slow_req | i_wdt_on;
      o_wdt_run = i_wdt_on;
      if (i_halted) begin
         o_slow_en = i_wdt_on & i_wdt_stby;
         o_wdt_run = i_wdt_on & i_wdt_stby;
         o_sub_en  = hsc_keep(i_src == `HSC_SRC_SUBSYS, i_sub_prev);
         o_fast_en = hsc_keep(i_src == `HSC_SRC_FAST_OSC, i_fast_prev);
         o_xtal_en = hsc_keep(1'b0, i_xtal_prev);
         o_ext_en  = hsc_keep(1'b0, i_ext_prev);
         case (i_src)
            `HSC_SRC_CRYSTAL: begin
               o_xtal_en = 1'b1;
               o_ext_en  = 1'b0;
            end
            `HSC_SRC_EXT_CLK: begin
               o_ext_en  = 1'b1;
               o_xtal_en = 1'b0;
            end
            default: begin
               o_xtal_en = hsc_keep(1'b0, i_xtal_prev);
            end
         endcase
      end
   end

endmodule // hsc_clk_policy

// ---- rtl/hsc_consts.vh ----
`ifndef HSC_CONSTS_VH
`define HSC_CONSTS_VH

// ==========================================================================
// CPU clock source codes
// ==========================================================================
`define HSC_SRC_W          2
`define HSC_SRC_FAST_OSC   2'h0
`define HSC_SRC_CRYSTAL    2'h1
`define HSC_SRC_EXT_CLK    2'h2
`define HSC_SRC_SUBSYS     2'h3

// ==========================================================================
// Option byte layout
// ==========================================================================
`define HSC_OPT_ADDR       20'h000C0
`define HSC_OPT_STBY_BIT   0
`define HSC_OPT_WDT_ON_BIT 4

// ==========================================================================
// Release wait, in CPU clocks, shortest figure of each range
// ==========================================================================
`define HSC_WAIT_W         4
`define HSC_WAIT_VEC_MAIN  4'hA
`define HSC_WAIT_VEC_SUB   4'h8
`define HSC_WAIT_NXT_MAIN  4'h5
`define HSC_WAIT_NXT_SUB   4'h3

// ==========================================================================
// Reset values
// ==========================================================================
`define HSC_PORT_RST       8'h00

`endif

// ---- rtl/hsc_halt_control.v ----
// Functional notes
// - Halt instruction enters the halt state.
// - Entry allowed from every CPU clock source.
// - CPU clock gated off while halted.
// - Fast oscillator forced on if CPU source.
// - Crystal source: crystal on, external input off.
// - External source: input on, crystal off.
// - Subsystem crystal keeps its pre-halt state, forced on if CPU source.
// - Slow oscillator runs only if both bits set.
// - Watchdog counts only if both bits set.
// - Flash stays usable in low-current mode.
// - RAM accesses stop, contents kept.
// - Port latches hold their pre-halt values.
// - Timer array keeps its clock.
// - Unmasked interrupt releases halt, vectored or next.
// - Reset releases halt and restarts at vector.
`timescale 1ns/1ps
`include "hsc_consts.vh"

module hsc_halt_control #(
   parameter PORT_W = 8
) (
   // Clock and reset
   input  wire                    i_sys_clk,
   input  wire                    i_arst_n,
   // CPU side
   input  wire                    i_halt_exec,
   input  wire [`HSC_SRC_W-1:0]   i_cpu_src,
   input  wire                    i_int_req,
   input  wire                    i_int_ack_en,
   input  wire                    i_rst_req,
   // Clock generator requests
   input  wire                    i_fast_req,
   input  wire                    i_xtal_req,
   input  wire                    i_ext_req,
   input  wire                    i_sub_req,
   input  wire                    i_slow_req,
   // Option byte
   input  wire [7:0]              i_opt_byte,
   // Peripheral requests
   input  wire                    i_timer_run,
   input  wire                    i_port_we,
   input  wire [PORT_W-1:0]       i_port_wdata,
   // Clock enables
   output reg                     o_cpu_clk_en,
   output reg                     o_fast_osc_en,
   output reg                     o_xtal_en,
   output reg                     o_ext_clk_en,
   output reg                     o_subxtal_en,
   output reg                     o_slow_osc_en,
   // Peripheral controls
   output reg                     o_wdt_run,
   output reg                     o_flash_lowpwr,
   output reg                     o_ram_en,
   output reg                     o_timer_clk_en,
   output reg  [PORT_W-1:0]       o_port_q,
   // Status and resume strobes
   output reg                     o_halted,
   output reg                     o_resume_vec,
   output reg                     o_resume_next,
   output reg                     o_rst_vector
);

   // =======================================================================
   // States
   // =======================================================================
   localparam [2:0] ST_RUN  = 3'h1;
   localparam [2:0] ST_HALT = 3'h2;
   localparam [2:0] ST_WAKE = 3'h4;

   reg  [2:0]              state;
   reg  [2:0]              next_state;
   reg                     halted;
   reg                     next_halted;
   reg  [`HSC_SRC_W-1:0]   src_lat;
   reg  [`HSC_SRC_W-1:0]   next_src_lat;
   reg  [`HSC_WAIT_W-1:0]  wait_cnt;
   reg  [`HSC_WAIT_W-1:0]  next_wait_cnt;
   reg                     wake_vec;
   reg                     next_wake_vec;
   reg                     fast_prev;
   reg                     xtal_prev;
   reg                     ext_prev;
   reg                     sub_prev;
   reg                     opt_wdt_on;
   reg                     opt_stby;
   reg                     opt_done;
   reg                     rst_pend;
   reg                     go_halt;
   reg                     go_wake;
   reg                     go_run;
   reg                     go_rst;
   reg  [`HSC_WAIT_W-1:0]  wake_wait;

   wire                    pol_fast;
   wire                    pol_xtal;
   wire                    pol_ext;
   wire                    pol_sub;
   wire                    pol_slow;
   wire                    pol_wdt;

   // =======================================================================
   // Option byte capture
   // =======================================================================
   // Straps are sampled once after reset release, never under reset,
   // so a changing option word cannot glitch the watchdog policy.
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         opt_wdt_on <= 1'b0;
         opt_stby   <= 1'b0;
         opt_done   <= 1'b0;
      end else if (!opt_done) begin
         opt_wdt_on <= i_opt_byte[`HSC_OPT_WDT_ON_BIT];
         opt_stby   <= i_opt_byte[`HSC_OPT_STBY_BIT];
         opt_done   <= 1'b1;
      end
   end

   // =======================================================================
   // Release wait selection
   // =======================================================================
   // Subsystem clock is slower, so its wait figures are shorter in clocks
   always @* begin
      if (i_int_ack_en) begin
         if (src_lat == `HSC_SRC_SUBSYS) begin
            wake_wait = `HSC_WAIT_VEC_SUB;
         end else begin
            wake_wait = `HSC_WAIT_VEC_MAIN;
         end
      end else begin
         if (src_lat == `HSC_SRC_SUBSYS) begin
            wake_wait = `HSC_WAIT_NXT_SUB;
         end else begin
            wake_wait = `HSC_WAIT_NXT_MAIN;
         end
      end
   end

   // =======================================================================
   // Transition conditions
   // =======================================================================
   // Reset request wins over everything; halt entry is decoded only in run, interrupt only in halt
   always @* begin
      go_rst  = i_rst_req;
      go_halt = (state == ST_RUN) & i_halt_exec & ~i_rst_req;
      go_wake = (state == ST_HALT) & i_int_req & ~i_rst_req;
      go_run  = (state == ST_WAKE) & (wait_cnt == 4'h1) & ~i_rst_req;
   end

   // =======================================================================
   // State machine next values
   // =======================================================================
   always @* begin
      next_state    = state;
      next_halted   = halted;
      next_src_lat  = src_lat;
      next_wait_cnt = wait_cnt;
      next_wake_vec = wake_vec;
      case (state)
         ST_RUN: begin
            // Any of the four sources may be latched here
            if (go_halt) begin
               next_state   = ST_HALT;
               next_halted  = 1'b1;
               next_src_lat = i_cpu_src;
            end
         end
         ST_HALT: begin
            if (go_wake) begin
               next_state    = ST_WAKE;
               next_wait_cnt = wake_wait;
               next_wake_vec = i_int_ack_en;
            end
         end
         ST_WAKE: begin
            next_wait_cnt = wait_cnt - 4'h1;
            if (go_run) begin
               next_state  = ST_RUN;
               next_halted = 1'b0;
            end
         end
         default: begin
            next_state  = ST_RUN;
            next_halted = 1'b0;
         end
      endcase
      if (go_rst) begin
         next_state    = ST_RUN;
         next_halted   = 1'b0;
         next_wait_cnt = {`HSC_WAIT_W{1'b0}};
         next_wake_vec = 1'b0;
      end
   end

   // =======================================================================
   // State registers
   // =======================================================================
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state    <= ST_RUN;
         halted   <= 1'b0;
         src_lat  <= `HSC_SRC_FAST_OSC;
         wait_cnt <= {`HSC_WAIT_W{1'b0}};
         wake_vec <= 1'b0;
      end else begin
         state    <= next_state;
         halted   <= next_halted;
         src_lat  <= next_src_lat;
         wait_cnt <= next_wait_cnt;
         wake_vec <= next_wake_vec;
      end
   end

   // =======================================================================
   // Snapshot of oscillator states at halt entry
   // =======================================================================
   // Taken from the live requests in the entry cycle; software cannot
   // change them while the CPU is stopped, so the copy stays valid.
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fast_prev <= 1'b0;
         xtal_prev <= 1'b0;
         ext_prev  <= 1'b0;
         sub_prev  <= 1'b0;
      end else if (go_halt) begin
         fast_prev <= i_fast_req;
         xtal_prev <= i_xtal_req;
         ext_prev  <= i_ext_req;
         sub_prev  <= i_sub_req;
      end
   end

   // =======================================================================
   // Clock policy
   // =======================================================================
   // Fed the next halt flag so the enables change with the flag itself
   hsc_clk_policy u_policy (
      .i_halted    (next_halted),
      .i_src       (next_src_lat),
      .i_fast_req  (i_fast_req),
      .i_xtal_req  (i_xtal_req),
      .i_ext_req   (i_ext_req),
      .i_sub_req   (i_sub_req),
      .i_slow_req  (i_slow_req),
      .i_fast_prev (go_halt ? i_fast_req : fast_prev),
      .i_xtal_prev (go_halt ? i_xtal_req : xtal_prev),
      .i_ext_prev  (go_halt ? i_ext_req : ext_prev),
      .i_sub_prev  (go_halt ? i_sub_req : sub_prev),
      .i_wdt_on    (opt_wdt_on),
      .i_wdt_stby  (opt_stby),
      .o_fast_en   (pol_fast),
      .o_xtal_en   (pol_xtal),
      .o_ext_en    (pol_ext),
      .o_sub_en    (pol_sub),
      .o_slow_en   (pol_slow),
      .o_wdt_run   (pol_wdt)
   );

   // =======================================================================
   // Registered clock enables
   // =======================================================================
   // Reset leaves the fast oscillator running: it is the boot clock
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cpu_clk_en  <= 1'b1;
         o_fast_osc_en <= 1'b1;
         o_xtal_en     <= 1'b0;
         o_ext_clk_en  <= 1'b0;
         o_subxtal_en  <= 1'b0;
         o_slow_osc_en <= 1'b0;
         o_wdt_run     <= 1'b0;
      end else begin
         o_cpu_clk_en  <= ~next_halted;
         o_fast_osc_en <= pol_fast;
         o_xtal_en     <= pol_xtal;
         o_ext_clk_en  <= pol_ext;
         o_subxtal_en  <= pol_sub;
         o_slow_osc_en <= pol_slow;
         o_wdt_run     <= pol_wdt;
      end
   end

   // =======================================================================
   // Memory and timer controls
   // =======================================================================
   // RAM is only fenced off; its supply is untouched so data survives
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_flash_lowpwr <= 1'b0;
         o_ram_en       <= 1'b1;
         o_timer_clk_en <= 1'b0;
      end else begin
         o_flash_lowpwr <= next_halted;
         o_ram_en       <= ~next_halted;
         o_timer_clk_en <= i_timer_run;
      end
   end

   // =======================================================================
   // Port output latch
   // =======================================================================
   // Writes are blocked while halted, so the pins keep their last value
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_port_q <= `HSC_PORT_RST;
      end else if (i_port_we && !halted) begin
         o_port_q <= i_port_wdata;
      end
   end

   // =======================================================================
   // Status and resume strobes
   // =======================================================================
   // One reset-vector pulse after async reset release as well as on a
   // synchronous reset request; the CPU restarts from it in both cases.
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_pend      <= 1'b1;
         o_halted      <= 1'b0;
         o_resume_vec  <= 1'b0;
         o_resume_next <= 1'b0;
         o_rst_vector  <= 1'b0;
      end else begin
         rst_pend      <= 1'b0;
         o_halted      <= next_halted;
         o_resume_vec  <= go_run & wake_vec;
         o_resume_next <= go_run & ~wake_vec;
         o_rst_vector  <= go_rst | rst_pend;
      end
   end

endmodule // hsc_halt_control

// ---- verification/halt_standby_control_test.sv ----
`timescale 1ns/1ps
`include "hsc_consts.vh"

// ==================================================================
// Halt controller bench
module halt_standby_control_test;
   logic       i_sys_clk, i_arst_n, i_halt_exec, i_int_req, i_int_ack_en, i_rst_req;
   logic [1:0] i_cpu_src;
   logic       i_fast_req, i_xtal_req, i_ext_req, i_sub_req, i_slow_req;
   logic [7:0] i_opt_byte, i_port_wdata, o_port_q;
   logic       i_timer_run, i_port_we, halt_go, int_go;
   logic       o_cpu_clk_en, o_fast_osc_en, o_xtal_en, o_ext_clk_en, o_subxtal_en;
   logic       o_slow_osc_en, o_wdt_run, o_flash_lowpwr, o_ram_en, o_timer_clk_en;
   logic       o_halted, o_resume_vec, o_resume_next, o_rst_vector;
   logic [7:0] opts [3] = '{8'h00, 8'h01, 8'h10};
   int         err_total, total_checks, cycles;

   hsc_halt_control #(.PORT_W(8)) u_hsc_halt_control (.*);
   hsc_cpu_model u_hsc_cpu_model (
      .i_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_halt_go(halt_go), .i_int_go(int_go),
      .i_halted(o_halted), .i_resume(o_resume_vec | o_resume_next),
      .o_halt_exec(i_halt_exec), .o_int_req(i_int_req));

   // 40 MHz clock
   always #12.5 i_sys_clk = ~i_sys_clk;

   // Hang guard; the full run needs well under a thousand cycles
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         summarize();
      end
   end

   // ==================================================================
   // Compare and report
   task automatic chk_bit(input string nm, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==================================================================
   // Scenarios
   task automatic do_reset(input logic [7:0] opt);
      @(posedge i_sys_clk);
      i_arst_n <= 1'b0;
      i_opt_byte <= opt;
      // Timer request dropped with an all-zero option word to see the gate off
      i_timer_run <= |opt;
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk_bit("reset cpu clk", 1'b1, o_cpu_clk_en);
      chk_bit("reset halted", 1'b0, o_halted);
      chk_val("reset port", 8'h00, o_port_q);
      @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      @(posedge i_sys_clk);
      #1;
      chk_bit("reset vector", 1'b1, o_rst_vector);
      @(posedge i_sys_clk);
   endtask

   // Halt from one source, poke the port, wake by interrupt and time the wait
   task automatic halt_src(input logic [1:0] src, input logic [3:0] req,
                           input logic ack, input logic [7:0] n);
      logic [7:0] cnt;
      logic       on;
      on = i_opt_byte[4] & i_opt_byte[0];
      @(posedge i_sys_clk);
      i_cpu_src <= src;
      {i_fast_req, i_xtal_req, i_ext_req, i_sub_req} <= req;
      i_int_ack_en <= ack;
      i_port_we <= 1'b1;
      i_port_wdata <= {src, req, 2'h1};
      halt_go <= 1'b1;
      @(posedge i_sys_clk);
      i_port_we <= 1'b0;
      halt_go <= 1'b0;
      for (cnt = 0; cnt < 8 && o_halted !== 1'b1; cnt++) begin
         @(posedge i_sys_clk);
         #1;
      end
      chk_bit("halted", 1'b1, o_halted);
      chk_bit("cpu clk", 1'b0, o_cpu_clk_en);
      chk_bit("ram", 1'b0, o_ram_en);
      chk_bit("flash low", 1'b1, o_flash_lowpwr);
      chk_bit("timer clk", i_timer_run, o_timer_clk_en);
      chk_bit("fast", src == `HSC_SRC_FAST_OSC || req[3], o_fast_osc_en);
      chk_bit("xtal", src == `HSC_SRC_CRYSTAL || (src != `HSC_SRC_EXT_CLK && req[2]),
              o_xtal_en);
      chk_bit("ext", src == `HSC_SRC_EXT_CLK || (src != `HSC_SRC_CRYSTAL && req[1]),
              o_ext_clk_en);
      chk_bit("subxtal", src == `HSC_SRC_SUBSYS || req[0], o_subxtal_en);
      chk_bit("slow osc", on, o_slow_osc_en);
      chk_bit("wdt", on, o_wdt_run);
      @(posedge i_sys_clk);
      i_port_we <= 1'b1;
      i_port_wdata <= ~{src, req, 2'h1};
      int_go <= 1'b1;
      @(posedge i_sys_clk);
      i_port_we <= 1'b0;
      int_go <= 1'b0;
      #1;
      // Count from the edge at which the controller takes the interrupt
      for (cnt = 0; cnt < 20; cnt++) begin
         @(posedge i_sys_clk);
         #1;
         if ((o_resume_vec | o_resume_next) === 1'b1)
            break;
      end
      chk_val("wait cycles", n, cnt);
      chk_bit("resume vec", ack, o_resume_vec);
      chk_bit("resume next", !ack, o_resume_next);
      chk_bit("cpu clk back", 1'b1, o_cpu_clk_en);
      chk_val("port held", {src, req, 2'h1}, o_port_q);
   endtask

   // Synchronous reset request while halted
   task automatic rst_in_halt();
      @(posedge i_sys_clk);
      halt_go <= 1'b1;
      @(posedge i_sys_clk);
      halt_go <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      i_rst_req <= 1'b1;
      #1;
      chk_bit("halted pre", 1'b1, o_halted);
      @(posedge i_sys_clk);
      i_rst_req <= 1'b0;
      #1;
      chk_bit("rst vector", 1'b1, o_rst_vector);
      chk_bit("rst halted", 1'b0, o_halted);
      chk_bit("rst cpu clk", 1'b1, o_cpu_clk_en);
   endtask

   // ==================================================================
   // Main sequence; slow request held up so halt must override it
   initial begin
      i_sys_clk = 1'b0;
      i_arst_n = 1'b0;
      {i_rst_req, i_int_ack_en, i_cpu_src, i_port_we, i_port_wdata} = '0;
      {i_fast_req, i_xtal_req, i_ext_req, i_sub_req, halt_go, int_go} = '0;
      i_slow_req = 1'b1;
      i_timer_run = 1'b1;
      i_opt_byte = 8'h11;
      err_total = 0;
      total_checks = 0;
      cycles = 0;
      do_reset(8'h11);
      halt_src(`HSC_SRC_FAST_OSC, 4'h0, 1'b1, 8'h0A);
      halt_src(`HSC_SRC_CRYSTAL, 4'h3, 1'b0, 8'h05);
      halt_src(`HSC_SRC_EXT_CLK, 4'hC, 1'b1, 8'h0A);
      halt_src(`HSC_SRC_SUBSYS, 4'hE, 1'b0, 8'h03);
      halt_src(`HSC_SRC_SUBSYS, 4'h1, 1'b1, 8'h08);
      rst_in_halt();
      foreach (opts[i]) begin
         do_reset(opts[i]);
         halt_src(`HSC_SRC_FAST_OSC, 4'hF, 1'b0, 8'h05);
      end
      summarize();
   end
endmodule // halt_standby_control_test

// ---- verification/hsc_cpu_model.sv ----
`timescale 1ns/1ps

// ==================================================================
// CPU stand-in: one-cycle halt instruction, interrupt held until served
module hsc_cpu_model (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   // Bench commands
   input  wire logic i_halt_go,
   input  wire logic i_int_go,
   // Controller status
   input  wire logic i_halted,
   input  wire logic i_resume,
   // To controller
   output logic      o_halt_exec,
   output logic      o_int_req
);
   // A pending request stays up until the controller resumes, as a flag would
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_halt_exec <= 1'b0;
         o_int_req <= 1'b0;
      end else begin
         o_halt_exec <= i_halt_go && !i_halted;
         if (i_int_go)
            o_int_req <= 1'b1;
         else if (i_resume)
            o_int_req <= 1'b0;
      end
   end
endmodule // hsc_cpu_model

// ---- verification/hsc_halt_properties.sv ----
`timescale 1ns/1ps
`include "hsc_consts.vh"

// ==================================================================
// Halt controller checker
module hsc_halt_properties #(
   parameter PORT_W = 8
) (
   // Clock, reset and CPU side
   input wire logic              i_sys_clk,
   input wire logic              i_arst_n,
   input wire logic              i_halt_exec,
   input wire logic [1:0]        i_cpu_src,
   input wire logic              i_int_req,
   input wire logic              i_int_ack_en,
   input wire logic              i_rst_req,
   input wire logic [7:0]        i_opt_byte,
   // Controller outputs
   input wire logic              o_cpu_clk_en,
   input wire logic              o_fast_osc_en,
   input wire logic              o_xtal_en,
   input wire logic              o_ext_clk_en,
   input wire logic              o_subxtal_en,
   input wire logic              o_slow_osc_en,
   input wire logic              o_wdt_run,
   input wire logic              o_flash_lowpwr,
   input wire logic              o_ram_en,
   input wire logic [PORT_W-1:0] o_port_q,
   input wire logic              o_halted,
   input wire logic              o_resume_vec,
   input wire logic              o_resume_next,
   input wire logic              o_rst_vector
);
   reg  [1:0] src_q;
   reg        wait_q;
   wire       take;
   wire       stby_on;

   // Interrupt taken only once per halt, so later edges of the wait are excluded
   assign take = o_halted && i_int_req && !i_rst_req && !wait_q;
   assign stby_on = i_opt_byte[`HSC_OPT_WDT_ON_BIT] && i_opt_byte[`HSC_OPT_STBY_BIT];

   // Own record of the source latched at entry and of a pending release
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         src_q <= 2'h0;
         wait_q <= 1'b0;
      end else begin
         if (!o_halted && i_halt_exec && !i_rst_req)
            src_q <= i_cpu_src;
         wait_q <= (wait_q || take) && o_halted && !i_rst_req;
      end
   end

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);

   a_halt_entry: assert property (
      !o_halted && i_halt_exec && !i_rst_req |=> o_halted && o_flash_lowpwr)
      else $error("halt entry not answered");
   a_cpu_gated: assert property (
      o_halted |-> !o_cpu_clk_en && !o_ram_en) else $error("cpu clock or ram live in halt");
   a_fast_forced: assert property (
      o_halted && src_q == `HSC_SRC_FAST_OSC |-> o_fast_osc_en)
      else $error("fast oscillator stopped");
   a_xtal_source: assert property (
      o_halted && src_q == `HSC_SRC_CRYSTAL |-> o_xtal_en && !o_ext_clk_en)
      else $error("crystal source policy wrong");
   a_ext_source: assert property (
      o_halted && src_q == `HSC_SRC_EXT_CLK |-> o_ext_clk_en && !o_xtal_en)
      else $error("external source policy wrong");
   a_subxtal_keep: assert property (
      o_halted && src_q != `HSC_SRC_SUBSYS |-> $stable(o_subxtal_en))
      else $error("subsystem crystal changed");
   a_slow_policy: assert property (
      o_halted |-> o_slow_osc_en == stby_on) else $error("slow oscillator policy wrong");
   a_wdt_policy: assert property (
      o_halted |-> o_wdt_run == stby_on) else $error("watchdog policy wrong");
   a_port_hold: assert property (
      o_halted && !i_rst_req |=> $stable(o_port_q)) else $error("port latch changed");
   a_wake_vectored: assert property (
      take && i_int_ack_en && src_q != `HSC_SRC_SUBSYS |-> ##10 o_halted
      ##1 (o_resume_vec && !o_halted && o_cpu_clk_en)) else $error("vectored wake timing");
   a_wake_next: assert property (
      take && !i_int_ack_en && src_q == `HSC_SRC_SUBSYS |-> ##3 o_halted
      ##1 (o_resume_next && !o_halted && o_cpu_clk_en)) else $error("next wake timing");
   a_reset_release: assert property (
      i_rst_req |=> o_rst_vector && !o_halted && o_cpu_clk_en)
      else $error("reset request not answered");

   c_halt: cover property ($rose(o_halted));
   c_vectored: cover property (take && i_int_ack_en);
   c_reset_halt: cover property (i_rst_req && o_halted);
endmodule // hsc_halt_properties

bind hsc_halt_control hsc_halt_properties #(.PORT_W(PORT_W)) u_hsc_halt_properties (.*);
